// [rtl/sbc_device.sv]
// device end: shadow chain, working registers, boost select
`timescale 1ns/1ps
`default_nettype none
`include "sbc_map.svh"
module sbc_device
  import sbc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          clkEn,
  input  wire sbc_code_arr_t boostSelectPins,
  output sbc_code_arr_t      boostCode,
  output logic               overrideOn,
  sbc_link_if.dev            link
);

  // ==========================================================
  // link synchronisers
  // all three link wires pass the same first two flops, so the
  // data keeps its place relative to the serial clock edge
  logic sclkS1_q, sclkS1_d;
  logic sclkS2_q, sclkS2_d;
  logic sclkS3_q, sclkS3_d;
  logic sdiS1_q, sdiS1_d;
  logic sdiS2_q, sdiS2_d;
  logic enS1_q, enS1_d;
  logic enS2_q, enS2_d;
  logic enS3_q, enS3_d;

  // next values of the sync stages
  always_comb begin
    sclkS1_d = link.sclk;
    sclkS2_d = sclkS1_q;
    sclkS3_d = sclkS2_q;
    sdiS1_d  = link.sdi;
    sdiS2_d  = sdiS1_q;
    enS1_d   = link.loadEnable_n;
    enS2_d   = enS1_q;
    enS3_d   = enS2_q;
  end

  // enable resets high so no latch fires on release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclkS1_q <= 1'b0;
      sclkS2_q <= 1'b0;
      sclkS3_q <= 1'b0;
      sdiS1_q  <= 1'b0;
      sdiS2_q  <= 1'b0;
      enS1_q   <= 1'b1;
      enS2_q   <= 1'b1;
      enS3_q   <= 1'b1;
    end else if (clkEn) begin
      sclkS1_q <= sclkS1_d;
      sclkS2_q <= sclkS2_d;
      sclkS3_q <= sclkS3_d;
      sdiS1_q  <= sdiS1_d;
      sdiS2_q  <= sdiS2_d;
      enS1_q   <= enS1_d;
      enS2_q   <= enS2_d;
      enS3_q   <= enS3_d;
    end
  end

  // ==========================================================
  // edge detection on the second and third stages only
  logic sclkRise;
  logic enLow;
  logic enRise;

  // a serial edge counts only inside a frame
  always_comb begin
    sclkRise = sclkS2_q & ~sclkS3_q;
    enLow    = ~enS2_q;
    enRise   = enS2_q & ~enS3_q;
  end

  // ==========================================================
  // shadow chain and daisy output
  // index 0 is register 1, index 20 is register 21
  logic [`SBC_CHAIN_LEN-1:0] shadow_q, shadow_d;
  logic                      sdo_q, sdo_d;

  // shift one place per serial clock while the enable is low;
  // older bits simply fall off the top of the chain
  always_comb begin
    shadow_d = shadow_q;
    sdo_d    = sdo_q;
    if (enLow && sclkRise) begin
      shadow_d = {shadow_q[`SBC_CHAIN_LEN-2:0], sdiS2_q};
      sdo_d    = shadow_d[`SBC_CHAIN_LEN-1];
    end
  end

  // the chain clears on reset, yet its first contents are don't-care
  // and show on the daisy output until the chain has filled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shadow_q <= 21'h000000;
      sdo_q    <= 1'b0;
    end else if (clkEn) begin
      shadow_q <= shadow_d;
      sdo_q    <= sdo_d;
    end
  end

  assign link.sdo = sdo_q;

  // ==========================================================
  // working registers
  logic [`SBC_CHAIN_LEN-1:0] work_q, work_d;

  // the working set changes only on the enable's rising edge,
  // so a half-shifted frame never reaches the equalizers
  always_comb begin
    work_d = work_q;
    if (enRise) begin
      work_d = shadow_q;
    end
  end

  // power-up value clears the override bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      work_q <= `SBC_WORK_RESET;
    end else if (clkEn) begin
      work_q <= work_d;
    end
  end

  // ==========================================================
  // boost select per channel
  logic ovr;

  // override bit lives in register 1
  always_comb begin
    ovr = work_q[`SBC_OVR_POS];
  end

  logic ovr_q, ovr_d;

  always_comb begin
    ovr_d = ovr;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ovr_q <= 1'b0;
    end else if (clkEn) begin
      ovr_q <= ovr_d;
    end
  end

  assign overrideOn = ovr_q;

  // control pins are static straps but still cross domains,
  // so each channel gets its own two-stage synchroniser
  genvar ch;
  generate
    for (ch = 0; ch < `SBC_NUM_CH; ch++) begin : g_chan
      sbc_code_t pinS1_q, pinS1_d;
      sbc_code_t pinS2_q, pinS2_d;
      sbc_code_t field;
      sbc_code_t code_q, code_d;

      // field of register 2+5*ch upward, lowest register as lsb
      always_comb begin
        field = work_q[`SBC_FIELD_BASE + ch*`SBC_CODE_W +: `SBC_CODE_W];
      end

      // pin synchronisers and the select between the two sources
      always_comb begin
        pinS1_d = boostSelectPins[ch];
        pinS2_d = pinS1_q;
        code_d  = ovr ? field : pinS2_q;
      end

      // reset shows code zero until the pins are sampled
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          pinS1_q <= 5'h00;
          pinS2_q <= 5'h00;
          code_q  <= 5'h00;
        end else if (clkEn) begin
          pinS1_q <= pinS1_d;
          pinS2_q <= pinS2_d;
          code_q  <= code_d;
        end
      end

      assign boostCode[ch] = code_q;
    end
  endgenerate

endmodule : sbc_device
`default_nettype wire

// [rtl/sbc_host.sv]
// host controller: apb registers in, serial link out
`timescale 1ns/1ps
`default_nettype none
`include "sbc_map.svh"
module sbc_host
  import sbc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  sbc_link_if.host         link
);

  // ==========================================================
  // apb slave
  logic [31:0] data0_q, data0_d, data1_q, data1_d, prdata_q, prdata_d;
  logic [6:0]  len_q, len_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic        done_q, done_d, go;
  logic        busy, finish, wrAcc, hit;

  // one wait-free access: pready rises in the access cycle
  always_comb begin
    wrAcc     = psel & penable & pready_q & pwrite;
    hit       = paddr == `SBC_ADDR_CTRL || paddr == `SBC_ADDR_STAT ||
                paddr == `SBC_ADDR_DATA0 || paddr == `SBC_ADDR_DATA1;
    pready_d  = psel & ~penable;
    pslverr_d = psel & ~penable & ~hit;
    prdata_d  = prdata_q;
    data0_d   = data0_q;
    data1_d   = data1_q;
    len_d     = len_q;
    go        = 1'b0;
    done_d    = done_q;
    if (psel && !penable) begin
      unique case (paddr)
        `SBC_ADDR_CTRL:  prdata_d = {17'h00000, len_q, 8'h00};
        `SBC_ADDR_STAT:  prdata_d = {30'h00000000, done_q, busy};
        `SBC_ADDR_DATA0: prdata_d = data0_q;
        `SBC_ADDR_DATA1: prdata_d = data1_q;
        default:         prdata_d = 32'h00000000;
      endcase
    end
    if (wrAcc && paddr == `SBC_ADDR_CTRL) begin
      len_d = pwdata[`SBC_CTRL_LEN_HI:`SBC_CTRL_LEN_LO];
      // the device needs a whole frame, and the shifter holds 64
      if (len_d < 7'(`SBC_CHAIN_LEN)) len_d = 7'(`SBC_CHAIN_LEN);
      if (len_d > `SBC_LEN_MAX) len_d = `SBC_LEN_MAX;
      go = pwdata[`SBC_CTRL_GO] & ~busy;
    end
    if (wrAcc && paddr == `SBC_ADDR_DATA0) data0_d = pwdata;
    if (wrAcc && paddr == `SBC_ADDR_DATA1) data1_d = pwdata;
    // write one clears done, but a finishing frame wins
    if (wrAcc && paddr == `SBC_ADDR_STAT && pwdata[`SBC_STAT_DONE]) done_d = 1'b0;
    if (finish) done_d = 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      data0_q   <= 32'h00000000;
      data1_q   <= 32'h00000000;
      len_q     <= `SBC_LEN_RESET;
      done_q    <= 1'b0;
    end else if (clkEn) begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      data0_q   <= data0_d;
      data1_q   <= data1_d;
      len_q     <= len_d;
      done_q    <= done_d;
    end
  end

  // ==========================================================
  // serial sequencer, clock made by dividing clk
  sbc_host_state_t st_q, st_d;
  logic [63:0] shift_q, shift_d;
  logic [6:0]  left_q, left_d;
  logic [3:0]  tmr_q, tmr_d;
  logic        sclk_q, sclk_d, sdi_q, sdi_d, en_q, en_d;

  always_comb begin
    st_d    = st_q;
    shift_d = shift_q;
    left_d  = left_q;
    tmr_d   = tmr_q;
    sclk_d  = sclk_q;
    sdi_d   = sdi_q;
    en_d    = en_q;
    finish  = 1'b0;
    busy    = st_q != SBC_IDLE;
    if (tmr_q != 4'h0) begin
      tmr_d = tmr_q - 4'h1;
    end else begin
      unique case (st_q)
        SBC_IDLE: begin
          if (go) begin
            // left-align so the first bit sent is the farthest register
            shift_d = {data1_q, data0_q} << (7'h40 - len_d);
            left_d  = len_d;
            en_d    = 1'b0;
            tmr_d   = 4'(`SBC_TSCK_CYC - 1);
            st_d    = SBC_SETUP;
          end
        end
        SBC_SETUP: begin
          sdi_d = shift_q[63];
          tmr_d = 4'(`SBC_HALF_CYC - 1);
          st_d  = SBC_LOW;
        end
        SBC_LOW: begin
          sclk_d = 1'b1;
          tmr_d  = 4'(`SBC_HALF_CYC - 1);
          st_d   = SBC_HIGH;
        end
        SBC_HIGH: begin
          sclk_d  = 1'b0;
          shift_d = {shift_q[62:0], 1'b0};
          left_d  = left_q - 7'h01;
          if (left_q == 7'h01) begin
            tmr_d = 4'(`SBC_THEN_CYC - 1);
            st_d  = SBC_HOLD;
          end else begin
            sdi_d = shift_q[62];
            tmr_d = 4'(`SBC_HALF_CYC - 1);
            st_d  = SBC_LOW;
          end
        end
        SBC_HOLD: begin
          en_d  = 1'b1;
          tmr_d = 4'(`SBC_THEN_CYC - 1);
          st_d  = SBC_GAP;
        end
        SBC_GAP: begin
          finish = 1'b1;
          st_d   = SBC_IDLE;
        end
        default: st_d = SBC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q    <= SBC_IDLE;
      shift_q <= 64'h0000000000000000;
      left_q  <= 7'h00;
      tmr_q   <= 4'h0;
      sclk_q  <= 1'b0;
      sdi_q   <= 1'b0;
      en_q    <= 1'b1;
    end else if (clkEn) begin
      st_q    <= st_d;
      shift_q <= shift_d;
      left_q  <= left_d;
      tmr_q   <= tmr_d;
      sclk_q  <= sclk_d;
      sdi_q   <= sdi_d;
      en_q    <= en_d;
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign link.sclk         = sclk_q;
  assign link.sdi          = sdi_q;
  assign link.loadEnable_n = en_q;

endmodule : sbc_host
`default_nettype wire

// [rtl/sbc_link_if.sv]
// three-wire serial link plus daisy output
`timescale 1ns/1ps
`default_nettype none
interface sbc_link_if;
  logic sclk;
  logic sdi;
  logic loadEnable_n;
  logic sdo;

  modport host (
    output sclk,
    output sdi,
    output loadEnable_n,
    input  sdo
  );

  modport dev (
    input  sclk,
    input  sdi,
    input  loadEnable_n,
    output sdo
  );
endinterface : sbc_link_if
`default_nettype wire

// [rtl/sbc_map.svh]
// constants of the serial boost configuration shifter
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH

// ==========================================================
// serial chain layout
`define SBC_CHAIN_LEN   21
`define SBC_OVR_POS     0
`define SBC_FIELD_BASE  1
`define SBC_CODE_W      5
`define SBC_NUM_CH      4
`define SBC_WORK_RESET  21'h000000

// ==========================================================
// timing
`define SBC_CLK_KHZ     40000
`define SBC_SCLK_MAX_KHZ 20000
`define SBC_SCLK_KHZ    5000
`define SBC_HALF_CYC    (`SBC_CLK_KHZ / (2 * `SBC_SCLK_KHZ))
`define SBC_TSCK_NS     100
`define SBC_TSCK_CYC    ((`SBC_TSCK_NS * `SBC_CLK_KHZ + 999999) / 1000000)
`define SBC_THEN_NS     100
`define SBC_THEN_CYC    ((`SBC_THEN_NS * `SBC_CLK_KHZ + 999999) / 1000000)

// ==========================================================
// host register map (apb byte addresses)
`define SBC_ADDR_CTRL   8'h00
`define SBC_ADDR_STAT   8'h04
`define SBC_ADDR_DATA0  8'h08
`define SBC_ADDR_DATA1  8'h0C
`define SBC_CTRL_GO     0
`define SBC_CTRL_LEN_LO 8
`define SBC_CTRL_LEN_HI 14
`define SBC_STAT_BUSY   0
`define SBC_STAT_DONE   1
`define SBC_LEN_RESET   7'h15
`define SBC_LEN_MAX     7'h40

`endif

// [rtl/sbc_pkg.sv]
// types shared by both ends of the serial boost link
package sbc_pkg;

  typedef logic [4:0] sbc_code_t;
  typedef logic [3:0][4:0] sbc_code_arr_t;

  // gray codes along idle, setup, bit loop, hold, gap
  typedef enum logic [2:0] {
    SBC_IDLE  = 3'h0,
    SBC_SETUP = 3'h1,
    SBC_LOW   = 3'h3,
    SBC_HIGH  = 3'h2,
    SBC_HOLD  = 3'h6,
    SBC_GAP   = 3'h4
  } sbc_host_state_t;

endpackage : sbc_pkg

// [sim/sbc_link_asserts.sv]
// checker of the serial link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module sbc_link_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic loadEnable_n,
  input wire logic sdo
);
  logic [20:0] histQ, histD;
  logic [6:0]  frameQ, frameD;
  logic [4:0]  shiftQ, shiftD;
  logic        sclkQ;
  logic        rise;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // history of shifted bits, counted per frame and since reset
  assign rise = sclk && !sclkQ && !loadEnable_n;
  always_comb begin
    histD  = rise ? {histQ[19:0], sdi} : histQ;
    frameD = loadEnable_n ? 7'h00 : frameQ + {6'h00, rise};
    shiftD = (rise && shiftQ != 5'h14) ? shiftQ + 5'h01 : shiftQ; // saturates at 20
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {histQ, frameQ, shiftQ, sclkQ} <= '0;
    end else begin
      {histQ, frameQ, shiftQ, sclkQ} <= {histD, frameD, shiftD, sclk};
    end
  end

  // ==========================================================
  // link timing
  sequence s_high;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_low;
    !sclk [*4];
  endsequence
  a_setup_time: assert property ($fell(loadEnable_n) |-> s_low) else $error("clock rose too soon");
  a_release_hold: assert property ($rose(loadEnable_n) |-> !$past(sclk, 1) && !$past(sclk, 4))
    else $error("enable released too soon");
  a_gap_time: assert property ($rose(loadEnable_n) |-> loadEnable_n [*4]) else $error("frame gap short");
  a_clock_framed: assert property (loadEnable_n |-> !sclk) else $error("clock outside frame");
  a_high_phase: assert property ($rose(sclk) |-> s_high) else $error("high phase wrong");
  a_low_phase: assert property ($fell(sclk) |-> s_low) else $error("low phase short");
  a_data_held: assert property (sclk |-> $stable(sdi)) else $error("data moved at clock");
  a_frame_length: assert property ($rose(loadEnable_n) |-> frameQ >= 7'h15) else $error("frame too short");
  a_daisy_delay: assert property (rise && shiftQ == 5'h14 |-> ##5 sdo == $past(histQ[19], 5))
    else $error("daisy output wrong");
  a_idle_quiet: assert property (loadEnable_n && $past(loadEnable_n, 6) |-> $stable(sdo))
    else $error("output moved while idle");
endmodule : sbc_link_asserts
`default_nettype wire

// [sim/tb_serial_boost_config_shifter.sv]
// bench: host and device joined over the link, driven through apb
`timescale 1ns/1ps
`default_nettype none
`include "sbc_map.svh"
module tb_serial_boost_config_shifter
  import sbc_pkg::*;
;
  logic          clk, reset, psel, penable, pwrite, pready, pslverr, ovr, e, clkEn;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, q;
  logic [63:0]   w, prevW;
  sbc_code_arr_t pins, code, expC;
  int            errors, tests_run;
  int            cycles = 0;
  int            lens[5] = '{21, 30, 5, 64, 100};

  sbc_link_if link ();
  sbc_host i_sbc_host (.clk(clk), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  sbc_device i_sbc_device (.clk(clk), .reset(reset), .clkEn(clkEn), .boostSelectPins(pins),
    .boostCode(code), .overrideOn(ovr), .link(link));
  sbc_link_asserts i_sbc_link_asserts (.clk(clk), .reset(reset), .sclk(link.sclk), .sdi(link.sdi),
    .loadEnable_n(link.loadEnable_n), .sdo(link.sdo));

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at an edge,
  // with no local limit: only the bench timeout ends a hung wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk); // a gap edge so psel is never assigned twice at once
  endtask : apb

  // boost per channel: field of the last 21 bits when override is set, else pins
  function automatic sbc_code_arr_t exp_code(input logic [63:0] x, input sbc_code_arr_t p);
    sbc_code_arr_t r;
    for (int k = 0; k < 4; k++) r[k] = x[0] ? x[5*k+1 +: 5] : p[k];
    return r;
  endfunction : exp_code

  task automatic summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    clkEn = 1'b1;
    {pins, prevW, errors, tests_run} = '0;
    reset = 1'b1;
    void'($urandom(32'h3C788D42));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    pins <= sbc_code_arr_t'($urandom);
    repeat (6) @(posedge clk);
    chk(ovr, 0);
    chk(code, pins);
    // clock enable low freezes the pin path: a new strap value must not show
    expC = pins;
    clkEn <= 1'b0;
    pins <= sbc_code_arr_t'($urandom);
    repeat (6) @(posedge clk);
    chk(code, expC);
    clkEn <= 1'b1;
    apb(0, `SBC_ADDR_CTRL, 0);
    chk(q, 32'h00001500);
    apb(0, 8'h10, 0); // unmapped place reads zero with an error
    chk(q, 32'h00000000);
    chk(e, 1'b1);
    apb(1, 8'h14, 32'hFFFFFFFF);
    chk(e, 1);
    // corner lengths first (exact, overlong, clamped up, maximum, clamped down), then random ones
    for (int i = 0; i < 12; i++) begin
      int len;
      len = (i < 5) ? lens[i] : 21 + $urandom_range(19);
      w = {$urandom, $urandom};
      if (i < 5) w[0] = ~i[0];
      pins <= sbc_code_arr_t'($urandom);
      repeat (6) @(posedge clk);
      expC = exp_code(prevW, pins);
      chk(code, expC);
      apb(1, `SBC_ADDR_DATA0, w[31:0]);
      apb(1, `SBC_ADDR_DATA1, w[63:32]);
      apb(1, `SBC_ADDR_CTRL, (32'(len) << 8) | 32'h1);
      do begin
        apb(0, `SBC_ADDR_STAT, 0);
        if (link.loadEnable_n === 1'b0) chk(code, expC);
      end while (q[1] !== 1'b1);
      repeat (6) @(posedge clk);
      chk(ovr, w[0]);
      chk(code, exp_code(w, pins));
      apb(0, `SBC_ADDR_CTRL, 0);
      chk(q[14:8], (len < 21) ? 21 : (len > 64) ? 64 : len);
      apb(1, `SBC_ADDR_STAT, 32'h2);
      apb(0, `SBC_ADDR_STAT, 0);
      chk(q, 0);
      prevW = w;
    end
    summarize();
  end
endmodule : tb_serial_boost_config_shifter
`default_nettype wire
